// ===== rtl/four_bit_port.sv
// Operation
// RL1: Output direction reads back the latch
// RL2: Input direction reads the pin level
// RL3: Pin latch resets to F0
// RL4: Direction bit one drives, zero receives
// RL5: Direction register resets to F0
// RL6: Direction register write-only, reads all ones
// RL7: Latch and direction act only in I/O
// RL8: Pin 0 common 1 unless I/O forced
// RL9: Pin 1 common 2 by duplex or duty
// RL10: Pin 2 common 3 by duplex or duty
// RL11: Pin 3 common 4 by duplex or duty
// RL12: Hi-Z in reset/standby, hold in sleeps
// RL13: Upper latch bits ignore writes, read one
`timescale 1ns/10ps
`default_nettype none
module four_bit_port (
   input  wire logic                      ref_clk,     // System clock
   input  wire logic                      rst_n,       // Async reset, low
   input  wire logic [15:0]               addr,        // Register address
   input  wire logic [7:0]                wdata,       // Write data
   input  wire logic                      wr_en,       // Write strobe
   input  wire logic                      rd_en,       // Read strobe
   output logic      [7:0]                rdata,       // Read data, next cycle
   input  wire port_pkg::power_mode_t     power_mode,  // Operating mode class
   input  wire logic [3:0]                lcd_common,  // Common lines 1..4
   input  wire logic [3:0]                pin_in,      // Pin levels
   output logic      [3:0]                pin_out,     // Pin drive value
   output logic      [3:0]                pin_oe,      // Pin drive enable
   output logic      [3:0]                common_sel   // Pin in common mode
);
   logic [3:0] latch_reg, latch_next;
   logic [3:0] dir_reg, dir_next;
   logic [7:0] lcd_reg, lcd_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [3:0] out_reg, out_next;
   logic [3:0] oe_reg, oe_next;
   logic [3:0] com_mux;
   logic [3:0] seg_sel;
   logic       seg_ext, common_duplex_select, io_forced;
   logic [1:0] duty;

   assign seg_sel   = lcd_reg[port_pkg::SEG_SEL_LSB +: 4];
   assign seg_ext   = lcd_reg[port_pkg::SEG_EXT_BIT];
   assign common_duplex_select       = lcd_reg[port_pkg::COMMON_DUP_BIT];
   assign duty      = lcd_reg[port_pkg::DUTY_LSB +: 2];
   assign io_forced = !seg_ext && seg_sel == port_pkg::SEG_SEL_IO;

   always_comb begin
      com_mux[0] = !io_forced;                                             // [RL8]
      com_mux[1] = !io_forced && (common_duplex_select || duty != port_pkg::DUTY_STATIC);   // [RL9]
      com_mux[2] = !io_forced && (common_duplex_select || (duty != port_pkg::DUTY_STATIC
                                  && duty != port_pkg::DUTY_HALF));        // [RL10]
      com_mux[3] = !io_forced && (common_duplex_select || duty == port_pkg::DUTY_QUARTER);  // [RL11]
   end

   always_comb begin
      latch_next = latch_reg;
      dir_next   = dir_reg;
      lcd_next   = lcd_reg;
      if (wr_en) begin
         unique case (addr)
            port_pkg::ADDR_PIN_LATCH: latch_next = wdata[3:0];   // [RL13]
            port_pkg::ADDR_DIRECTION: dir_next   = wdata[3:0];
            port_pkg::ADDR_LCD_CTRL:  lcd_next   = wdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      rdata_next = port_pkg::RDATA_IDLE;
      if (rd_en) begin
         unique case (addr)
            port_pkg::ADDR_PIN_LATCH:
               rdata_next = {port_pkg::UNUSED_ONES,
                             (dir_reg & latch_reg) | (~dir_reg & pin_in)};   // [RL1] [RL2] [RL13]
            port_pkg::ADDR_DIRECTION: rdata_next = port_pkg::ALL_ONES;       // [RL6]
            port_pkg::ADDR_LCD_CTRL:  rdata_next = lcd_reg;
            default: ;
         endcase
      end
   end

   // Sleep classes freeze the pads so the panel keeps its last level
   always_comb begin
      out_next = out_reg;
      oe_next  = oe_reg;
      unique case (power_mode)
         port_pkg::MODE_HIZ: begin
            oe_next = 4'h0;                                                // [RL12]
         end
         port_pkg::MODE_HOLD: ;                                            // [RL12]
         port_pkg::MODE_RUN: begin
            for (int i = 0; i < 4; i++) begin
               out_next[i] = com_mux[i] ? lcd_common[i] : latch_reg[i];    // [RL7]
               oe_next[i]  = com_mux[i] | dir_reg[i];                      // [RL4] [RL7]
            end
         end
         default: oe_next = 4'h0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_reg <= port_pkg::PIN_LATCH_RESET[3:0];   // [RL3]
         dir_reg   <= port_pkg::DIRECTION_RESET[3:0];   // [RL5]
         lcd_reg   <= port_pkg::LCD_CTRL_RESET;
         rdata_reg <= port_pkg::RDATA_IDLE;
         out_reg   <= port_pkg::PIN_OUT_RESET;
         oe_reg    <= port_pkg::PIN_OE_RESET;           // [RL12]
      end else begin
         latch_reg <= latch_next;
         dir_reg   <= dir_next;
         lcd_reg   <= lcd_next;
         rdata_reg <= rdata_next;
         out_reg   <= out_next;
         oe_reg    <= oe_next;
      end
   end

   assign rdata      = rdata_reg;
   assign pin_out    = out_reg;
   assign pin_oe     = oe_reg;
   assign common_sel = com_mux;

   // Bus requests; each is one cycle wide
   sequence s_dir_read;
      rd_en && addr == port_pkg::ADDR_DIRECTION;
   endsequence

   sequence s_dir_write;
      wr_en && addr == port_pkg::ADDR_DIRECTION;
   endsequence

   sequence s_latch_read;
      rd_en && addr == port_pkg::ADDR_PIN_LATCH;
   endsequence

   sequence s_latch_write;
      wr_en && addr == port_pkg::ADDR_PIN_LATCH;
   endsequence

   sequence s_ctrl_read;
      rd_en && addr == port_pkg::ADDR_LCD_CTRL;
   endsequence

   sequence s_ctrl_write;
      wr_en && addr == port_pkg::ADDR_LCD_CTRL;
   endsequence

   // Pad classes as seen at the edge that loads the pad flops
   sequence s_run;
      power_mode == port_pkg::MODE_RUN;
   endsequence

   sequence s_hold;
      power_mode == port_pkg::MODE_HOLD;
   endsequence

   sequence s_hiz;
      power_mode == port_pkg::MODE_HIZ;
   endsequence

   // No disable on its users: they watch the reset itself
   sequence s_in_reset;
      !rst_n;
   endsequence

   // Register bus
   AST_DIR_READS_ONES: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL6]
      s_dir_read |=> rdata == port_pkg::ALL_ONES)
      else $error("direction read not all ones");

   AST_DIR_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL4]
      s_dir_write |=> dir_reg == $past(wdata[3:0]))
      else $error("direction write wrong");

   AST_LATCH_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL1] [RL2]
      s_latch_read |=> rdata[3:0] == (($past(dir_reg) & $past(latch_reg))
                                     | (~$past(dir_reg) & $past(pin_in))))
      else $error("latch read wrong");

   AST_UPPER_READ_ONES: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL13]
      s_latch_read |=> rdata[7:4] == port_pkg::UNUSED_ONES)
      else $error("upper latch bits not ones");

   AST_UPPER_IGNORED: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL13]
      s_latch_write |=> latch_reg == $past(wdata[3:0]))
      else $error("latch write wrong");

   AST_CTRL_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL7]
      s_ctrl_write |=> lcd_reg == $past(wdata))
      else $error("panel control write wrong");

   AST_CTRL_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL7]
      s_ctrl_read |=> rdata == $past(lcd_reg))
      else $error("panel control read wrong");

   AST_OUT_READ_0: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL1]
      rd_en && addr == port_pkg::ADDR_PIN_LATCH && dir_reg[0]
      |=> rdata[0] == $past(latch_reg[0]))
      else $error("output pin 0 not read from latch");

   AST_OUT_READ_1: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL1]
      rd_en && addr == port_pkg::ADDR_PIN_LATCH && dir_reg[1]
      |=> rdata[1] == $past(latch_reg[1]))
      else $error("output pin 1 not read from latch");

   AST_OUT_READ_2: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL1]
      rd_en && addr == port_pkg::ADDR_PIN_LATCH && dir_reg[2]
      |=> rdata[2] == $past(latch_reg[2]))
      else $error("output pin 2 not read from latch");

   AST_OUT_READ_3: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL1]
      rd_en && addr == port_pkg::ADDR_PIN_LATCH && dir_reg[3]
      |=> rdata[3] == $past(latch_reg[3]))
      else $error("output pin 3 not read from latch");

   AST_INPUT_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL2]
      rd_en && addr == port_pkg::ADDR_PIN_LATCH && !dir_reg[0]
      |=> rdata[0] == $past(pin_in[0]))
      else $error("input pin 0 not read");

   AST_IN_READ_1: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL2]
      rd_en && addr == port_pkg::ADDR_PIN_LATCH && !dir_reg[1]
      |=> rdata[1] == $past(pin_in[1]))
      else $error("input pin 1 not read");

   AST_IN_READ_2: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL2]
      rd_en && addr == port_pkg::ADDR_PIN_LATCH && !dir_reg[2]
      |=> rdata[2] == $past(pin_in[2]))
      else $error("input pin 2 not read");

   AST_IN_READ_3: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL2]
      rd_en && addr == port_pkg::ADDR_PIN_LATCH && !dir_reg[3]
      |=> rdata[3] == $past(pin_in[3]))
      else $error("input pin 3 not read");

   // Pad drive and register reset values
   AST_OE_RUN: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL4]
      s_run |=> pin_oe == ($past(com_mux) | $past(dir_reg)))
      else $error("drive enable wrong");

   AST_OUT_RUN: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL7]
      s_run |=> pin_out == (($past(com_mux) & $past(lcd_common))
                           | (~$past(com_mux) & $past(latch_reg))))
      else $error("drive value wrong");

   AST_IO_DRIVE: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL7]
      power_mode == port_pkg::MODE_RUN && !com_mux[0] |=> pin_out[0] == $past(latch_reg[0]))
      else $error("io pin not from latch");

   AST_COMMON_DRIVE: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL7]
      power_mode == port_pkg::MODE_RUN && com_mux[3]
      |=> pin_out[3] == $past(lcd_common[3]) && pin_oe[3])
      else $error("common pin not driven from line");

   AST_HIZ: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL12]
      s_hiz |=> pin_oe == 4'h0)
      else $error("pins driven in standby");

   AST_HOLD_FREEZE: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL12]
      s_hold |=> $stable(pin_out) && $stable(pin_oe))
      else $error("pins moved in hold");

   AST_RESET_HIZ: assert property (@(posedge ref_clk)   // [RL12]
      s_in_reset |=> pin_oe == 4'h0)
      else $error("pins driven in reset");

   AST_RESET_REGS: assert property (@(posedge ref_clk)   // [RL3] [RL5]
      s_in_reset |=> latch_reg == port_pkg::PIN_LATCH_RESET[3:0]
                     && dir_reg == port_pkg::DIRECTION_RESET[3:0])
      else $error("reset values wrong");

   // Pin function select
   AST_PIN0_COM: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL8]
      (seg_ext || seg_sel != port_pkg::SEG_SEL_IO) |-> com_mux[0])
      else $error("pin 0 not common");

   AST_FORCED_IO: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL8]
      io_forced |-> com_mux == 4'h0)
      else $error("forced io pin in common mode");

   AST_PIN1_COM: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL9]
      !io_forced && !common_duplex_select && duty == port_pkg::DUTY_STATIC |-> !com_mux[1])
      else $error("pin 1 select wrong");

   AST_PIN1_ON: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL9]
      !io_forced && !common_duplex_select && duty == port_pkg::DUTY_HALF
      |-> com_mux[1] && !com_mux[3])
      else $error("pin 1 not common");

   AST_PIN2_COM: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL10]
      !io_forced && !common_duplex_select && duty == port_pkg::DUTY_HALF |-> !com_mux[2] && com_mux[1])
      else $error("pin 2 select wrong");

   AST_PIN2_ON: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL10]
      !io_forced && !common_duplex_select && duty != port_pkg::DUTY_STATIC
      && duty != port_pkg::DUTY_HALF |-> com_mux[2])
      else $error("pin 2 not common");

   AST_PIN3_COM: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL11]
      !io_forced && common_duplex_select |-> com_mux[3])
      else $error("pin 3 select wrong");

   AST_PIN3_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)   // [RL11]
      !io_forced && !common_duplex_select && duty != port_pkg::DUTY_QUARTER |-> !com_mux[3])
      else $error("pin 3 common too early");
endmodule : four_bit_port
`default_nettype wire

// ===== rtl/port_pkg.sv
package port_pkg;
   localparam logic [15:0] ADDR_PIN_LATCH   = 16'hFFDD;
   localparam logic [15:0] ADDR_DIRECTION   = 16'hFFED;
   localparam logic [15:0] ADDR_LCD_CTRL    = 16'hFFC0;
   localparam logic [7:0]  PIN_LATCH_RESET  = 8'hF0;
   localparam logic [7:0]  DIRECTION_RESET  = 8'hF0;
   localparam logic [7:0]  LCD_CTRL_RESET   = 8'h00;
   localparam logic [7:0]  RDATA_IDLE       = 8'h00;
   localparam logic [3:0]  PIN_OUT_RESET    = 4'h0;
   localparam logic [3:0]  PIN_OE_RESET     = 4'h0;
   localparam logic [3:0]  UNUSED_ONES      = 4'hF;
   localparam logic [7:0]  ALL_ONES         = 8'hFF;
   localparam int          SEG_SEL_LSB      = 0;
   localparam int          SEG_EXT_BIT      = 4;
   localparam int          COMMON_DUP_BIT   = 5;
   localparam int          DUTY_LSB         = 6;
   localparam logic [3:0]  SEG_SEL_IO       = 4'h0;
   localparam logic [1:0]  DUTY_STATIC      = 2'h0;
   localparam logic [1:0]  DUTY_HALF        = 2'h1;
   localparam logic [1:0]  DUTY_QUARTER     = 2'h3;
   typedef enum logic [1:0] {MODE_RUN, MODE_HIZ, MODE_HOLD} power_mode_t;
endpackage : port_pkg

// ===== test/pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module pin_model (
   input  wire logic [3:0] pin_out,  // Block drive value
   input  wire logic [3:0] pin_oe,   // Block drive enable
   input  wire logic [3:0] ext_val,  // Level the board applies
   output logic      [3:0] pin_in    // Resolved pin level
);
   // Board yields wherever the block drives, so no contention
   assign pin_in = (pin_out & pin_oe) | (ext_val & ~pin_oe);
endmodule : pin_model
`default_nettype wire

// ===== test/test_four_bit_port.sv
`timescale 1ns/10ps
`default_nettype none
module test_four_bit_port;
   logic                  ref_clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic [15:0]           addr = 16'h0000;
   logic [7:0]            wdata = 8'h00;
   logic                  wr_en = 1'b0;
   logic                  rd_en = 1'b0;
   logic [7:0]            rdata;
   port_pkg::power_mode_t power_mode = port_pkg::MODE_RUN;
   logic [3:0]            lcd_common = 4'h5;
   logic [3:0]            ext_val = 4'hA;
   logic [3:0]            pin_in, pin_out, pin_oe, common_sel, cs, eo;
   int                    bad_count = 0;
   int                    comparisons = 0;
   // Row: control byte, then expected common-mode pins
   logic [11:0]           rows [9] = '{12'h000, 12'h200, 12'h011, 12'h413, 12'h817,
                                       12'hC1F, 12'h21F, 12'h101, 12'hD0F};
   always #5 ref_clk = ~ref_clk;
   four_bit_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .power_mode(power_mode),
      .lcd_common(lcd_common), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .common_sel(common_sel));
   pin_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_in(pin_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd
   // Pins are registered one cycle behind the register state
   task automatic pins(input logic [3:0] oe, input logic [3:0] out);
      repeat (3) @(posedge ref_clk);
      #1 chk({4'h0, pin_oe}, {4'h0, oe});
      chk({4'h0, pin_out}, {4'h0, out});
   endtask : pins
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude
   initial begin
      pins(4'h0, 4'h0);
      @(posedge ref_clk) rst_n <= 1'b1;
      wr(port_pkg::ADDR_PIN_LATCH, 8'h0A);
      foreach (rows[i]) begin
         cs = rows[i][3:0];
         eo = (cs & lcd_common) | (~cs & 4'hA);
         wr(port_pkg::ADDR_LCD_CTRL, rows[i][11:4]);
         #1 chk({4'h0, common_sel}, {4'h0, cs});
         pins(cs, eo);
         rd(port_pkg::ADDR_PIN_LATCH, {4'hF, eo});
      end
      rd(port_pkg::ADDR_LCD_CTRL, 8'hD0);
      @(posedge ref_clk) rst_n <= 1'b0;
      pins(4'h0, 4'h0);
      @(posedge ref_clk) rst_n <= 1'b1;
      rd(port_pkg::ADDR_PIN_LATCH, 8'hFA);
      rd(port_pkg::ADDR_DIRECTION, 8'hFF);
      wr(port_pkg::ADDR_DIRECTION, 8'h0F);
      rd(port_pkg::ADDR_PIN_LATCH, 8'hF0);
      wr(port_pkg::ADDR_PIN_LATCH, 8'hA5);
      rd(port_pkg::ADDR_PIN_LATCH, 8'hF5);
      pins(4'hF, 4'h5);
      rd(port_pkg::ADDR_DIRECTION, 8'hFF);
      wr(port_pkg::ADDR_DIRECTION, 8'h03);
      rd(port_pkg::ADDR_PIN_LATCH, 8'hF9);
      rd(16'h1234, 8'h00);
      @(posedge ref_clk) power_mode <= port_pkg::MODE_HOLD;
      wr(port_pkg::ADDR_PIN_LATCH, 8'h0A);
      pins(4'h3, 4'h5);
      @(posedge ref_clk) power_mode <= port_pkg::MODE_RUN;
      pins(4'h3, 4'hA);
      @(posedge ref_clk) power_mode <= port_pkg::MODE_HIZ;
      repeat (3) @(posedge ref_clk);
      #1 chk({4'h0, pin_oe}, 8'h00);
      conclude();
   end
   initial begin
      #20000;
      bad_count++;
      conclude();
   end
endmodule : test_four_bit_port
`default_nettype wire
